//--- hdl/sbp_regs.svh
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH

// System clock
`define SBP_CLK_HZ 20000000
`define SBP_CLK_NS 50

// Oscillator prescaler
`define SBP_PRESCALE_RATIO 20

// Programmed divider ratios and digit codes
`define SBP_DIV_UPPER 85
`define SBP_DIV_LOWER 92
`define SBP_DIGIT_MAX 4'h9
`define SBP_DIGIT_ZERO 4'h0
`define SBP_START_UPPER 4'h7
`define SBP_START_LOWER 4'h0

// Reference divider rates
`define SBP_REF_HZ 20000
`define SBP_TONE_HZ 500
`define SBP_GATE_HZ 10
`define SBP_REF_HALF_CYC (`SBP_CLK_HZ / (2 * `SBP_REF_HZ))
`define SBP_TONE_HALF_CYC (`SBP_CLK_HZ / (2 * `SBP_TONE_HZ))
`define SBP_GATE_HALF_CYC (`SBP_CLK_HZ / (2 * `SBP_GATE_HZ))

// Lock discriminator width, rounded up to whole cycles
`define SBP_LOCK_WIDTH_NS 5000
`define SBP_LOCK_CYC ((`SBP_LOCK_WIDTH_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)

`endif

//--- hdl/sbp_pkg.sv
package sbp_pkg;
  // Mode switch level
  typedef enum logic {
    SBP_MODE_UPPER_AM = 1'b0,
    SBP_MODE_LOWER = 1'b1
  } sbp_mode_t;

  // One decimal digit of the divider
  typedef logic [3:0] sbp_digit_t;
endpackage : sbp_pkg

//--- hdl/sbp_divider_lock.sv
// Notes on behaviour
// - USB/AM gives 34.0MHz, LSB gives 36.8MHz.
// - Prescaler divides oscillator by fixed twenty.
// - Divide by 85 upper/AM, 92 lower.
// - Two decade digits clocked together, synchronous.
// - Count upward, terminal count is 91.
// - Low digit one, high carry marks nine.
// - Inverted terminal carry drives preset load.
// - Next edge loads seven or zero.
// - Cycle lasts 92 or 85 prescaled clocks.
// - Each reload emits one feedback pulse.
// - Compare feedback against 20kHz reference.
// - Rising edges set each input's flop.
// - Both flops set clears them both.
// - Comparator outputs merge into monitor pulse.
// - Pulse under about 5us means locked.
// - Latch holds lock decision per pulse.
// - Either loop unlocked gives out-of-lock.
// - Unlocked sounds 500Hz tone gated 10Hz.
// - Unlocked mutes both 1.4MHz outputs.
// - Lock status output drives indicator.
`timescale 1ns/1ns
`default_nettype none
`include "sbp_regs.svh"

module sbp_divider_lock #(
  parameter int LOCK_CYC = `SBP_LOCK_CYC,
  parameter int TONE_HALF_CYC = `SBP_TONE_HALF_CYC,
  parameter int GATE_HALF_CYC = `SBP_GATE_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pins from the analogue side and front panel
  input wire logic osc_clk_i,
  input wire logic lsb_sel_i,
  input wire logic main_monitor_i,
  // Phase comparator outputs to the charge pump, and the divider feedback pulse
  output logic pump_up_o,
  output logic pump_down_o,
  output logic feedback_pulse_o,
  // Lock status, alarm and mute
  output logic out_of_lock_o,
  output logic alarm_tone_o,
  output logic output_mute_o
);

  localparam int TONE_W = $clog2(TONE_HALF_CYC + 1);
  localparam int GATE_W = $clog2(GATE_HALF_CYC + 1);
  localparam int REF_W = $clog2(`SBP_REF_HALF_CYC + 1);

  // Decimal increment with wrap, used by both digits
  function automatic sbp_pkg::sbp_digit_t digit_inc(input sbp_pkg::sbp_digit_t d);
    digit_inc = (d == `SBP_DIGIT_MAX) ? `SBP_DIGIT_ZERO : d + 4'h1;
  endfunction : digit_inc

  // Pin synchronisers; stage one feeds only stage two
  logic [1:0] osc_sync;
  logic [1:0] mode_sync;
  logic [1:0] main_sync;
  logic osc_prev;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_sync <= 2'h0;
      mode_sync <= 2'h0;
      main_sync <= 2'h0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], osc_clk_i};
      mode_sync <= {mode_sync[0], lsb_sel_i};
      main_sync <= {main_sync[0], main_monitor_i};
      osc_prev <= osc_sync[1];
    end
  end

  logic osc_rise;
  assign osc_rise = osc_sync[1] & ~osc_prev;
  sbp_pkg::sbp_mode_t mode;
  assign mode = sbp_pkg::sbp_mode_t'(mode_sync[1]);

  // Fixed prescaler: one enable per twenty oscillator edges
  logic [4:0] pre_cnt;
  logic prescale_tick;
  assign prescale_tick = osc_rise && (pre_cnt == 5'(`SBP_PRESCALE_RATIO - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 5'h00;
    end else if (prescale_tick) begin
      pre_cnt <= 5'h00;
    end else if (osc_rise) begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // Programmed divider digits
  sbp_pkg::sbp_digit_t low_digit;
  sbp_pkg::sbp_digit_t high_digit;
  logic start_pending;
  logic low_carry;
  logic high_carry;
  logic terminal;
  logic preset_load_n;
  sbp_pkg::sbp_digit_t start_value;
  assign low_carry = (low_digit == `SBP_DIGIT_MAX);
  assign high_carry = (high_digit == `SBP_DIGIT_MAX);
  // low digit one from carry and lsb, high carry at nine
  assign terminal = high_carry & ~low_carry & low_digit[0];
  // inverted terminal carry is the preset load
  assign preset_load_n = ~terminal;
  // start value sets 85 or 92, so 34.0 or 36.8MHz
  assign start_value = (mode == sbp_pkg::SBP_MODE_LOWER) ? `SBP_START_LOWER : `SBP_START_UPPER;

  // Reset cannot sample the mode pin, so the first tick loads it
  // start from the selected load value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_pending <= 1'b1;
    end else if (prescale_tick) begin
      start_pending <= 1'b0;
    end
  end
  // digits tick together, cycle 85 or 92
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_digit <= `SBP_DIGIT_ZERO;
      high_digit <= `SBP_DIGIT_ZERO;
    end else if (prescale_tick) begin
      if (!preset_load_n || start_pending) begin
        // load zero or seven after terminal count
        low_digit <= start_value;
        high_digit <= `SBP_DIGIT_ZERO;
      end else begin
        low_digit <= digit_inc(low_digit);
        if (low_carry) begin
          high_digit <= digit_inc(high_digit);
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feedback_pulse_o <= 1'b0;
    end else begin
      feedback_pulse_o <= prescale_tick & ~preset_load_n;
    end
  end
  // Reference divider: 20kHz reference, 500Hz tone, 10Hz gate
  logic [REF_W-1:0] ref_cnt;
  logic [TONE_W-1:0] tone_cnt;
  logic [GATE_W-1:0] gate_cnt;
  logic ref_lvl;
  logic tone_lvl;
  logic gate_lvl;
  logic ref_half;
  assign ref_half = (ref_cnt == REF_W'(`SBP_REF_HALF_CYC - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_cnt <= '0;
      tone_cnt <= '0;
      gate_cnt <= '0;
      ref_lvl <= 1'b0;
      tone_lvl <= 1'b0;
      gate_lvl <= 1'b0;
    end else begin
      ref_cnt <= ref_half ? '0 : ref_cnt + REF_W'(1);
      if (ref_half) begin
        ref_lvl <= ~ref_lvl;
      end
      tone_cnt <= (tone_cnt == TONE_W'(TONE_HALF_CYC - 1)) ? '0 : tone_cnt + TONE_W'(1);
      if (tone_cnt == TONE_W'(TONE_HALF_CYC - 1)) begin
        tone_lvl <= ~tone_lvl;
      end
      gate_cnt <= (gate_cnt == GATE_W'(GATE_HALF_CYC - 1)) ? '0 : gate_cnt + GATE_W'(1);
      if (gate_cnt == GATE_W'(GATE_HALF_CYC - 1)) begin
        gate_lvl <= ~gate_lvl;
      end
    end
  end

  logic ref_rise;
  assign ref_rise = ref_half & ~ref_lvl;
  // Phase comparator flops; a fresh edge beats the clear
  logic pd_ref;
  logic pd_fb;
  logic pd_both;
  assign pd_both = pd_ref & pd_fb;
  // compare feedback with the 20kHz reference
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_ref <= 1'b0;
      pd_fb <= 1'b0;
    end else begin
      pd_ref <= (pd_ref & ~pd_both) | ref_rise;
      pd_fb <= (pd_fb & ~pd_both) | feedback_pulse_o;
    end
  end
  // Reference leading means oscillator slow: pump up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
    end else begin
      pump_up_o <= pd_ref;
      pump_down_o <= pd_fb;
    end
  end
  // Monitor pulses: index 0 main loop, 1 this loop
  logic [1:0] mon;
  logic [1:0] mon_prev;
  logic [1:0][7:0] width_cnt;
  logic [1:0] unlocked;
  logic [1:0] narrow_end;
  logic [1:0] wide_hit;
  // merge comparator outputs into one monitor
  assign mon = {pd_ref | pd_fb, main_sync[1]};
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // narrower than the threshold counts as locked
      narrow_end[i] = mon_prev[i] & ~mon[i] & (width_cnt[i] < 8'(LOCK_CYC));
      wide_hit[i] = mon[i] & (width_cnt[i] == 8'(LOCK_CYC - 1));
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_prev <= 2'h0;
      width_cnt <= '0;
    end else begin
      mon_prev <= mon;
      for (int i = 0; i < 2; i++) begin
        if (!mon[i]) begin
          width_cnt[i] <= 8'h00;
        end else if (width_cnt[i] < 8'(LOCK_CYC)) begin
          width_cnt[i] <= width_cnt[i] + 8'h01;
        end
      end
    end
  end

  // latch per loop, wide sets, narrow clears
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlocked <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wide_hit[i]) begin
          unlocked[i] <= 1'b1;
        end else if (narrow_end[i]) begin
          unlocked[i] <= 1'b0;
        end
      end
    end
  end

  // Status, alarm and mute all come from the same latches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_of_lock_o <= 1'b1;
      output_mute_o <= 1'b1;
      alarm_tone_o <= 1'b0;
    end else begin
      out_of_lock_o <= |unlocked;
      output_mute_o <= |unlocked;
      alarm_tone_o <= (|unlocked) & tone_lvl & gate_lvl;
    end
  end
  // Helper: osc edges and ticks between reloads
  logic [4:0] edges_seen;
  logic [6:0] ticks_seen;
  sbp_pkg::sbp_digit_t last_start;
  logic load_seen;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edges_seen <= 5'h00;
      ticks_seen <= 7'h00;
      last_start <= `SBP_DIGIT_ZERO;
      load_seen <= 1'b0;
    end else begin
      if (prescale_tick) begin
        edges_seen <= 5'h00;
      end else if (osc_rise) begin
        edges_seen <= edges_seen + 5'h01;
      end
      if (prescale_tick && !preset_load_n) begin
        ticks_seen <= 7'h01;
        last_start <= start_value;
        load_seen <= 1'b1;
      end else if (prescale_tick) begin
        ticks_seen <= ticks_seen + 7'h01;
      end
    end
  end

  AST_PRESCALE_TWENTY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prescale_tick |-> edges_seen == 5'(`SBP_PRESCALE_RATIO - 1)) else $error("prescale tick off twenty edges");
  AST_DIVIDE_RATIO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (prescale_tick && !preset_load_n && load_seen) |->
      ticks_seen == ((last_start == `SBP_START_LOWER) ? 7'(`SBP_DIV_LOWER) : 7'(`SBP_DIV_UPPER)))
    else $error("divider cycle length wrong");
  AST_LOAD_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (prescale_tick && !preset_load_n) |=> low_digit == $past(start_value) && high_digit == `SBP_DIGIT_ZERO)
    else $error("reload value wrong");
  AST_UP_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (prescale_tick && preset_load_n && !start_pending && !low_carry) |=>
      low_digit == $past(low_digit) + 4'h1 && high_digit == $past(high_digit)) else $error("not counting up");
  AST_TERMINAL_91: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !preset_load_n |-> high_digit == `SBP_DIGIT_MAX && low_digit == 4'h1) else $error("terminal not at 91");
  AST_FB_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (prescale_tick && !preset_load_n) |=> feedback_pulse_o ##1 !feedback_pulse_o) else $error("feedback width");
  AST_PFD_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pd_both && !ref_rise && !feedback_pulse_o) |=> !pd_ref && !pd_fb ##1 !pump_up_o && !pump_down_o)
    else $error("comparator flops not cleared");
  AST_PFD_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(pd_ref) |-> $past(ref_rise)) else $error("reference flop set without edge");
  AST_WIDE_UNLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wide_hit[1] |=> unlocked[1] ##1 out_of_lock_o) else $error("wide pulse did not unlock");
  AST_EITHER_LOOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    unlocked[0] |=> out_of_lock_o && output_mute_o) else $error("main loop loss not reported");
  AST_LOCK_NEEDS_NARROW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(out_of_lock_o) |-> $past(narrow_end[0], 2) || $past(narrow_end[1], 2)) else $error("lock without narrow");
  AST_ALARM_ONLY_UNLOCKED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    alarm_tone_o |-> out_of_lock_o && output_mute_o) else $error("alarm while locked");

endmodule : sbp_divider_lock
`default_nettype wire

//--- verif/sbp_far_side.sv
`timescale 1ns/1ns
`default_nettype none

module sbp_far_side (
  // Clock
  input wire logic clk_i,
  // Oscillator control
  input wire logic osc_run_i,
  input wire logic [3:0] osc_half_i,
  // Pins towards the block
  output logic osc_clk_o,
  output logic main_monitor_o
);
  int half_cnt;

  // Oscillator stand-in, stepped off clk so reload gaps are exact
  initial begin
    osc_clk_o = 1'h0;
    main_monitor_o = 1'h0;
    half_cnt = 0;
    forever begin
      @(posedge clk_i);
      #1;
      if (osc_run_i) begin
        half_cnt = half_cnt + 1;
        if (half_cnt >= int'(osc_half_i)) begin
          half_cnt = 0;
          osc_clk_o = ~osc_clk_o;
        end
      end
    end
  end

  // Main loop comparator pulse, width in clocks
  task automatic main_pulse(input int width);
    @(posedge clk_i);
    #1;
    main_monitor_o = 1'h1;
    repeat (width) @(posedge clk_i);
    #1;
    main_monitor_o = 1'h0;
  endtask : main_pulse
endmodule : sbp_far_side

`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbp_regs.svh"

module tb_top;
  // Oscillator half period in clocks; a full osc period is four clocks
  localparam int OSC_HALF = 2;
  localparam int LOCK = 20;
  localparam int UP_GAP = `SBP_DIV_UPPER * `SBP_PRESCALE_RATIO * 2 * OSC_HALF;
  localparam int LO_GAP = `SBP_DIV_LOWER * `SBP_PRESCALE_RATIO * 2 * OSC_HALF;

  logic clk_i;
  logic rst_n_i;
  logic osc_run;
  logic lsb_sel_i;
  logic osc_clk;
  logic main_mon;
  logic pump_up_o;
  logic pump_down_o;
  logic feedback_pulse_o;
  logic out_of_lock_o;
  logic alarm_tone_o;
  logic output_mute_o;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // Short tone and gate halves keep the alarm check brief
  sbp_divider_lock #(.LOCK_CYC(LOCK), .TONE_HALF_CYC(4), .GATE_HALF_CYC(16)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .osc_clk_i(osc_clk), .lsb_sel_i(lsb_sel_i),
    .main_monitor_i(main_mon), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o),
    .feedback_pulse_o(feedback_pulse_o), .out_of_lock_o(out_of_lock_o),
    .alarm_tone_o(alarm_tone_o), .output_mute_o(output_mute_o)
  );

  sbp_far_side far (
    .clk_i(clk_i), .osc_run_i(osc_run), .osc_half_i(4'h2),
    .osc_clk_o(osc_clk), .main_monitor_o(main_mon)
  );

  // Clock and cycle count
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Bounded wait for the next reload pulse
  task automatic wait_fb(input int lim, output int t);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (feedback_pulse_o !== 1'h1 && k < lim);
    check("feedback arrives", 1, feedback_pulse_o);
    t = cyc;
  endtask : wait_fb

  task automatic test_reset();
    check("pump_up", 0, pump_up_o);
    check("pump_down", 0, pump_down_o);
    check("feedback", 0, feedback_pulse_o);
    check("out_of_lock", 1, out_of_lock_o);
    check("mute", 1, output_mute_o);
  endtask : test_reset

  // Narrow main pulses cannot clear the status while this loop slips
  task automatic test_alarm();
    int hi;
    int mism;
    hi = 0;
    mism = 0;
    far.main_pulse(3);
    repeat (10) @(negedge clk_i);
    check("out_of_lock after narrow", 1, out_of_lock_o);
    check("main latch after narrow", 0, uut.unlocked[0]);
    far.main_pulse(LOCK + 5);
    repeat (10) @(negedge clk_i);
    repeat (64) begin
      @(negedge clk_i);
      if (alarm_tone_o === 1'h1) hi++;
      if (output_mute_o !== out_of_lock_o) mism++;
    end
    check("out_of_lock after wide", 1, out_of_lock_o);
    check("main latch after wide", 1, uut.unlocked[0]);
    check("alarm high cycles", 16, hi);
    check("mute vs status", 0, mism);
  endtask : test_alarm

  // Comparator around one reload; reference leads as the loop runs slow
  task automatic test_pumps();
    int k;
    @(negedge clk_i);
    check("feedback width", 0, feedback_pulse_o);
    @(negedge clk_i);
    check("pump_down set", 1, pump_down_o);
    check("pump_up held", 1, pump_up_o);
    @(negedge clk_i);
    check("pump_down clear", 0, pump_down_o);
    check("pump_up clear", 0, pump_up_o);
    k = 0;
    while (pump_up_o !== 1'h1 && k < 1010) begin
      @(negedge clk_i);
      k++;
    end
    check("pump_up rearm", 1, pump_up_o);
    check("pump_down idle", 0, pump_down_o);
  endtask : test_pumps

  // Reload spacing; a mode change only counts from the following reload
  task automatic test_divider();
    int t0;
    int t1;
    int t2;
    int t3;
    wait_fb(12000, t0);
    test_pumps();
    wait_fb(UP_GAP + 10, t1);
    check("upper gap", UP_GAP, t1 - t0);
    @(posedge clk_i);
    #1;
    lsb_sel_i = 1'h1;
    wait_fb(UP_GAP + 10, t2);
    check("gap before load", UP_GAP, t2 - t1);
    wait_fb(LO_GAP + 10, t3);
    check("lower gap", LO_GAP, t3 - t2);
  endtask : test_divider

  // Main sequence
  initial begin
    rst_n_i = 1'h0;
    lsb_sel_i = 1'h0;
    osc_run = 1'h0;
    @(negedge clk_i);
    test_reset();
    @(posedge clk_i);
    #1;
    rst_n_i = 1'h1;
    osc_run = 1'h1;
    @(negedge clk_i);
    test_reset();
    test_alarm();
    test_divider();
    conclude();
  end

  // Watchdog well beyond the roughly 30k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
endmodule : tb_top

`default_nettype wire
